// File: verification/chan_source.sv
// channel pin source model for the capture/compare array
`timescale 1ns/1ps
module chan_source #(
  parameter int NUM = 6
) (
  input wire logic pclk,
  input wire logic [NUM-1:0] want,
  input wire logic [NUM-1:0] channel_out,
  input wire logic [NUM-1:0] channel_oe,
  output logic [NUM-1:0] channel_in
);
  logic [NUM-1:0] lvl_q = '0;
  int held = 0;
  // each level stays at least three clocks
  always @(posedge pclk) begin
    if (held >= 2 && want != lvl_q) begin
      lvl_q <= want;
      held <= 0;
    end else begin
      held <= held + 1;
    end
  end
  // driven pins read back their own level
  assign channel_in = (channel_oe & channel_out) | (~channel_oe & lvl_q);
endmodule // chan_source

// File: verification/tb_cc_array.sv
// self-checking bench for the capture/compare array
`timescale 1ns/1ps
module tb_cc_array;
  import cc_pkg::*;
  localparam int N = 6;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [15:0] counter_value = '0;
  logic counter_tick = 1'b0;
  logic [N-1:0] want = '0;
  logic [N-1:0] channel_in;
  logic [N-1:0] channel_out;
  logic [N-1:0] channel_oe;
  logic [N-1:0] event_flags;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h76410d29;
  int mode, capv, arl, outv, flg, ovf, ie, m, n;
  always #25 pclk = ~pclk;
  cc_array #(.NUM(N)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_value(counter_value), .counter_tick(counter_tick),
    .channel_in(channel_in), .channel_out(channel_out), .channel_oe(channel_oe),
    .event_flags(event_flags), .irq(irq));
  chan_source #(.NUM(N)) i_src (.pclk(pclk), .want(want), .channel_out(channel_out),
    .channel_oe(channel_oe), .channel_in(channel_in));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    mode = 0;
    capv = 0;
    arl = 0;
    outv = 0;
    flg = 0;
    ovf = 0;
    ie = 0;
  endtask
  // one counter step, then compare with the model
  task automatic tick(input int c);
    int lm;
    @(posedge pclk);
    counter_value <= c[15:0];
    counter_tick <= 1'b1;
    @(posedge pclk);
    counter_tick <= 1'b0;
    lm = mode[7] ? 16'hFFFF : m;
    if ((c & m) == m) ovf = 1;
    if (mode[2] && mode[1]) begin
      if (mode[3] && c == capv) flg = 1;
      if (mode[6] && (c & 255) == (capv & 255)) begin
        outv ^= 1;
        capv = (capv & 16'hFF00) | ((capv + (capv >> 8)) & 255);
      end
    end else if (mode[1]) begin
      if (mode[6] && (c & lm) == (capv & lm)) begin
        outv = 1;
        flg |= mode[3];
      end
      if ((c & lm) == lm) begin
        outv = 0;
        if (!mode[7]) capv = (n == 8) ? ((capv & 16'hFF00) | (capv >> 8)) : (arl & m);
      end
      if (!mode[6]) outv = 0;
    end else if (mode[6] && mode[3] && c == capv) begin
      flg = 1;
      if (mode[2]) outv ^= 1;
    end
    #1;
    check("pin", channel_out, outv);
    check("flag", event_flags, flg);
    check("irq", irq, (flg & mode[0]) | (ovf & ie));
  endtask
  task automatic run_case(input int md, input int ln, input int hm, input int st, input int cnt);
    int r;
    do_reset();
    r = $random(seed);
    ie = md[1];
    n = 8 + ln;
    m = (1 << n) - 1;
    if (md[2] && md[1]) capv = (r & 255) | (((r >> 8) & hm) << 8);
    else if (md[1] && !md[7]) capv = (n == 8) ? (r & 16'h7F7F) : (r & (m >> 1));
    else capv = 16'hFFE8 + (r & 15);
    arl = (r >> 16) & (m >> 1);
    apb(1, PWM_CTRL_ADDR, ln | (ie << 5) | 8'h80);
    apb(1, LOW_BASE, arl & 255);
    apb(1, HIGH_BASE, arl >> 8);
    apb(0, LOW_BASE, 0);
    check("arl", rd, arl & 255);
    check("arl_err", er, 0);
    apb(1, PWM_CTRL_ADDR, ln | (ie << 5));
    apb(1, MODE_BASE, md | 8'h40);
    apb(1, LOW_BASE, capv & 255);
    apb(0, MODE_BASE, 0);
    check("ecom_low", rd[MB_ECOM], 0);
    apb(1, HIGH_BASE, capv >> 8);
    apb(0, MODE_BASE, 0);
    check("ecom_high", rd[MB_ECOM], 1);
    apb(1, MODE_BASE, md);
    mode = md;
    for (int i = 0; i < cnt; i++) tick((st + i) & 16'hFFFF);
    if (md == 8'h4D) begin
      apb(1, LOW_BASE, capv & 255);
      mode[6] = 0;
      for (int i = 0; i < cnt; i++) tick((st + i) & 16'hFFFF);
    end
    apb(0, PWM_CTRL_ADDR, 0);
    check("ovf", rd[PB_OVF], ovf);
    check("drive_oe", channel_oe[0], 1);
    $display("mode %h length %0d done", md, ln);
  endtask
  task automatic capture_test();
    int c;
    for (int s = 1; s < 4; s++) begin
      do_reset();
      apb(1, MODE_BASE, (s << 4) | 1);
      for (int e = 1; e >= 0; e--) begin
        c = $random(seed) & 16'hFFFF;
        counter_value <= c[15:0];
        apb(1, EVENT_ADDR, 1);
        flg = 0;
        want[0] <= e[0];
        repeat (8) @(posedge pclk);
        if (s[e]) begin
          capv = c;
          flg = 1;
        end
        apb(0, LOW_BASE, 0);
        check("cap_low", rd, capv & 255);
        apb(0, HIGH_BASE, 0);
        check("cap_high", rd, capv >> 8);
        check("cap_flag", event_flags, flg);
        check("cap_irq", irq, flg);
        check("cap_oe", channel_oe[0], 0);
      end
    end
    $display("capture tests done");
  endtask
  initial begin
    do_reset();
    capture_test();
    apb(0, 8'h80, 0);
    check("unmapped_err", er, 1);
    check("unmapped_data", rd, 0);
    $display("unmapped access done");
    run_case(8'h49, 0, 0, 16'hFFE0, 64);
    run_case(8'h4D, 0, 0, 16'hFFE0, 64);
    run_case(8'h47, 0, 255, 0, 600);
    run_case(8'h4F, 0, 1, 0, 600);
    run_case(8'h46, 0, 0, 0, 600);
    run_case(8'h4A, 0, 0, 0, 520);
    run_case(8'h4B, 1, 0, 0, 1032);
    run_case(8'h4A, 2, 0, 0, 2056);
    run_case(8'h4A, 3, 0, 0, 4104);
    run_case(8'hCB, 0, 0, 16'hFFE0, 64);
    run_case(8'h0A, 0, 0, 0, 300);
    give_verdict();
  end
endmodule // tb_cc_array

// File: verilog/cc_array.sv
// capture/compare module array with apb register access
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module cc_array #(
  parameter int NUM = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cc_pkg::ADDR_W-1:0] paddr,
  input wire logic [cc_pkg::DATA_W-1:0] pwdata,
  output logic [cc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] counter_value,
  input wire logic counter_tick,
  input wire logic [NUM-1:0] channel_in,
  output logic [NUM-1:0] channel_out,
  output logic [NUM-1:0] channel_oe,
  output logic [NUM-1:0] event_flags,
  output logic irq
);
  import cc_pkg::*;

  typedef struct packed {
    logic [NUM-1:0][7:0] mode;
    logic [NUM-1:0][15:0] cap;
    logic [NUM-1:0][15:0] arl;
    logic [NUM-1:0] pin;
    logic [NUM-1:0] sync1;
    logic [NUM-1:0] sync2;
    logic [NUM-1:0] last;
    logic [NUM-1:0] evt;
    logic [7:0] pwm;
    logic [31:0] rdata;
    logic slverr;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic setup;
  logic apb_wr;
  logic [2:0] idx;
  logic idx_ok;
  logic in_mode;
  logic in_low;
  logic in_high;
  logic in_pwm;
  logic in_evt;
  logic [31:0] rd;
  logic [15:0] mask;
  logic ovf_n;
  logic ovf_16;
  logic [NUM-1:0] capmode;
  logic [NUM-1:0] cap_hit;
  logic [NUM-1:0] m16;
  logic [NUM-1:0] m8;
  logic [NUM-1:0] mn;
  logic [NUM-1:0] hso;
  logic [NUM-1:0] freq;
  logic [NUM-1:0] pwm_n;
  logic [NUM-1:0] pwm_16;

  // mask of the counter bits used by the shared pwm length
  function automatic logic [15:0] len_mask(input logic [1:0] sel);
    logic [15:0] m;
    m = MASK_8;
    case (sel)
      LEN_8: m = MASK_8;
      LEN_9: m = MASK_9;
      LEN_10: m = MASK_10;
      default: m = MASK_11;
    endcase
    return m;
  endfunction

  always_comb begin
    s_d = s_q;
    setup = psel && !penable;
    apb_wr = psel && penable && pwrite;
    idx = paddr[4:2];
    idx_ok = (int'(idx) < NUM) && (paddr[1:0] == 2'b00);
    in_mode = 1'b0;
    in_low = 1'b0;
    in_high = 1'b0;
    in_pwm = 1'b0;
    in_evt = 1'b0;
    // address decode
    if (paddr == PWM_CTRL_ADDR) begin
      in_pwm = 1'b1;
    end else if (paddr == EVENT_ADDR) begin
      in_evt = 1'b1;
    end else if (paddr[7:5] == MODE_BASE[7:5] && idx_ok) begin
      in_mode = 1'b1;
    end else if (paddr[7:5] == LOW_BASE[7:5] && idx_ok) begin
      in_low = 1'b1;
    end else if (paddr[7:5] == HIGH_BASE[7:5] && idx_ok) begin
      in_high = 1'b1;
    end
    rd = RDATA_RST;
    if (in_pwm) begin
      rd[7:0] = s_q.pwm;
    end else if (in_evt) begin
      rd[NUM-1:0] = s_q.evt;
    end else if (in_mode) begin
      rd[7:0] = s_q.mode[idx];
    end else if (in_low) begin
      rd[7:0] = s_q.pwm[PB_ARSEL] ? s_q.arl[idx][7:0] : s_q.cap[idx][7:0];
    end else if (in_high) begin
      rd[7:0] = s_q.pwm[PB_ARSEL] ? s_q.arl[idx][15:8] : s_q.cap[idx][15:8];
    end
    if (setup) begin
      s_d.rdata = rd;
      s_d.slverr = !(in_pwm || in_evt || in_mode || in_low || in_high);
    end
    // software writes first, so hardware events win in the same cycle
    if (apb_wr) begin
      if (in_pwm) begin
        s_d.pwm = {pwdata[PB_ARSEL], s_q.pwm[PB_OVF] & pwdata[PB_OVF],
                   pwdata[PB_OVF_IE], 3'b000, pwdata[PB_LEN_HI:PB_LEN_LO]};
      end else if (in_evt) begin
        s_d.evt = s_q.evt & ~pwdata[NUM-1:0];
      end else if (in_mode) begin
        s_d.mode[idx] = pwdata[7:0];
      end else if (in_low) begin
        s_d.mode[idx][MB_ECOM] = 1'b0;
        if (s_q.pwm[PB_ARSEL]) begin
          s_d.arl[idx][7:0] = pwdata[7:0];
        end else begin
          s_d.cap[idx][7:0] = pwdata[7:0];
        end
      end else if (in_high) begin
        s_d.mode[idx][MB_ECOM] = 1'b1;
        if (s_q.pwm[PB_ARSEL]) begin
          s_d.arl[idx][15:8] = pwdata[7:0];
        end else begin
          s_d.cap[idx][15:8] = pwdata[7:0];
        end
      end
    end
    // shared length and intermediate overflow
    mask = len_mask(s_q.pwm[PB_LEN_HI:PB_LEN_LO]);
    ovf_n = counter_tick && ((counter_value & mask) == mask);
    ovf_16 = counter_tick && (counter_value == MASK_16);
    if (ovf_n) begin
      s_d.pwm[PB_OVF] = 1'b1;
    end
    for (int i = 0; i < NUM; i++) begin
      s_d.sync1[i] = channel_in[i];
      s_d.sync2[i] = s_q.sync1[i];
      s_d.last[i] = s_q.sync2[i];
      capmode[i] = (s_q.mode[i][MB_RISE] || s_q.mode[i][MB_FALL])
        && !s_q.mode[i][MB_MATCH] && !s_q.mode[i][MB_TOGGLE] && !s_q.mode[i][MB_PWM];
      // two stages: a level sampled on one clock edge is still seen, two clocks later
      cap_hit[i] = capmode[i]
        && ((s_q.mode[i][MB_RISE] && s_q.sync2[i] && !s_q.last[i])
        || (s_q.mode[i][MB_FALL] && !s_q.sync2[i] && s_q.last[i]));
      m16[i] = counter_value == s_q.cap[i];
      m8[i] = counter_value[7:0] == s_q.cap[i][7:0];
      mn[i] = (counter_value & mask) == (s_q.cap[i] & mask);
      pwm_16[i] = s_q.mode[i][MB_PWM] && s_q.mode[i][MB_PWM16];
      pwm_n[i] = s_q.mode[i][MB_PWM] && !s_q.mode[i][MB_PWM16]
        && !s_q.mode[i][MB_TOGGLE];
      freq[i] = s_q.mode[i][MB_PWM] && s_q.mode[i][MB_TOGGLE]
        && !s_q.mode[i][MB_PWM16];
      hso[i] = !s_q.mode[i][MB_PWM] && s_q.mode[i][MB_TOGGLE] && s_q.mode[i][MB_MATCH];
      if (cap_hit[i]) begin
        s_d.cap[i] = counter_value;
        s_d.evt[i] = 1'b1;
      end
      if (counter_tick) begin
        if (pwm_16[i]) begin
          if (!s_q.mode[i][MB_ECOM]) begin
            s_d.pin[i] = 1'b0;
          end else if (ovf_16) begin
            s_d.pin[i] = 1'b0;
          end else if (m16[i]) begin
            s_d.pin[i] = 1'b1;
            if (s_q.mode[i][MB_MATCH]) begin
              s_d.evt[i] = 1'b1;
            end
          end
        end else if (pwm_n[i]) begin
          if (ovf_n) begin
            s_d.pin[i] = 1'b0;
            if (s_q.pwm[PB_LEN_HI:PB_LEN_LO] == LEN_8) begin
              s_d.cap[i][7:0] = s_q.cap[i][15:8];
            end else begin
              s_d.cap[i] = s_q.arl[i] & mask;
            end
          end else if (mn[i] && s_q.mode[i][MB_ECOM]) begin
            s_d.pin[i] = 1'b1;
            if (s_q.mode[i][MB_MATCH]) begin
              s_d.evt[i] = 1'b1;
            end
          end
          if (!s_q.mode[i][MB_ECOM]) begin
            s_d.pin[i] = 1'b0;
          end
        end else if (freq[i] && s_q.mode[i][MB_ECOM]) begin
          if (m8[i]) begin
            s_d.pin[i] = !s_q.pin[i];
            // an 8-bit add of zero keeps the same value, so the next match comes 256 counter steps later
            s_d.cap[i][7:0] = 8'(s_q.cap[i][7:0] + s_q.cap[i][15:8]);
          end
          if (s_q.mode[i][MB_MATCH] && m16[i]) begin
            s_d.evt[i] = 1'b1;
          end
        end else if (!s_q.mode[i][MB_PWM] && s_q.mode[i][MB_MATCH]
                     && s_q.mode[i][MB_ECOM] && m16[i]) begin
          s_d.evt[i] = 1'b1;
          if (hso[i]) begin
            s_d.pin[i] = !s_q.pin[i];
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM; i++) begin
        s_q.mode[i] <= MODE_RST;
        s_q.cap[i] <= VALUE_RST;
        s_q.arl[i] <= VALUE_RST;
      end
      s_q.pin <= '0;
      s_q.sync1 <= '0;
      s_q.sync2 <= '0;
      s_q.last <= '0;
      s_q.evt <= '0;
      s_q.pwm <= PWM_CTRL_RST;
      s_q.rdata <= RDATA_RST;
      s_q.slverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr;
  assign pready = 1'b1;
  assign channel_out = s_q.pin;
  assign channel_oe = ~capmode;
  assign event_flags = s_q.evt;
  assign irq = |(s_q.evt & mode_ie(s_q.mode))
    || (s_q.pwm[PB_OVF] && s_q.pwm[PB_OVF_IE]);

  // gathers each module's interrupt enable bit
  function automatic logic [NUM-1:0] mode_ie(input logic [NUM-1:0][7:0] m);
    logic [NUM-1:0] r;
    r = '0;
    for (int i = 0; i < NUM; i++) begin
      r[i] = m[i][MB_IE];
    end
    return r;
  endfunction

  a_capture_value: assert property (@(posedge pclk) disable iff (!presetn)
    cap_hit[0] |=> s_q.cap[0] == $past(counter_value))
    else $error("capture did not load counter value");

  a_capture_flag: assert property (@(posedge pclk) disable iff (!presetn)
    cap_hit[0] |=> s_q.evt[0] ##1 (s_q.evt[0] || $past(apb_wr && in_evt)))
    else $error("capture flag not set or lost");

  a_edge_select: assert property (@(posedge pclk) disable iff (!presetn)
    (capmode[0] && s_q.mode[0][MB_RISE] && !s_q.mode[0][MB_FALL] && s_q.sync2[0]
     && !s_q.last[0]) |=> s_q.evt[0] && s_q.cap[0] == $past(counter_value))
    else $error("rising edge missed");

  a_edge_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    (capmode[0] && !s_q.mode[0][MB_RISE] && s_q.sync2[0] && !s_q.last[0] && !s_q.evt[0])
    |=> !s_q.evt[0])
    else $error("falling-only capture took a rising edge");

  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(channel_in[0]) ##1 channel_in[0] |=> s_q.sync2[0])
    else $error("synchroniser delay wrong");

  a_low_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && in_low && idx == 3'd0) |=> !s_q.mode[0][MB_ECOM])
    else $error("low write left enable set");

  a_high_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && in_high && idx == 3'd0) |=> s_q.mode[0][MB_ECOM])
    else $error("high write left enable clear");

  a_hso_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_tick && hso[0] && s_q.mode[0][MB_ECOM] && m16[0])
    |=> (s_q.pin[0] != $past(s_q.pin[0])) && s_q.evt[0])
    else $error("high-speed output did not toggle");

  a_hso_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (hso[0] && !s_q.mode[0][MB_ECOM]) |=> $stable(s_q.pin[0]))
    else $error("disabled high-speed output moved");

  a_pwm_off_low: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_tick && s_q.mode[0][MB_PWM] && !freq[0] && !s_q.mode[0][MB_ECOM])
    |=> !s_q.pin[0])
    else $error("disabled pwm output not low");

  a_freq_add: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_tick && freq[0] && s_q.mode[0][MB_ECOM] && m8[0] && !apb_wr)
    |=> s_q.cap[0][7:0] == 8'($past(s_q.cap[0][7:0]) + $past(s_q.cap[0][15:8])))
    else $error("frequency output step wrong");

  a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_n |=> s_q.pwm[PB_OVF])
    else $error("overflow flag not set");

  a_pwm8_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf_n && pwm_n[0] && s_q.pwm[1:0] == LEN_8 && !apb_wr)
    |=> s_q.cap[0][7:0] == $past(s_q.cap[0][15:8]) && !s_q.pin[0])
    else $error("8-bit pwm reload wrong");

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.evt[0] && s_q.mode[0][MB_IE]) |-> irq)
    else $error("enabled event without interrupt");

  a_swtimer_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_tick && !s_q.mode[0][MB_PWM] && s_q.mode[0][MB_MATCH] && s_q.mode[0][MB_ECOM]
     && counter_value == s_q.cap[0]) |=> s_q.evt[0])
    else $error("software timer match not flagged");

  a_freq_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_tick && freq[0] && s_q.mode[0][MB_ECOM] && s_q.mode[0][MB_MATCH]
     && counter_value == s_q.cap[0]) |=> s_q.evt[0])
    else $error("frequency output match not flagged");

  a_freq_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (freq[0] && !s_q.mode[0][MB_ECOM]) |=> $stable(s_q.pin[0]))
    else $error("disabled frequency output moved");

  a_pwm_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_tick && pwm_n[0] && s_q.mode[0][MB_ECOM] && !ovf_n
     && (counter_value & mask) == (s_q.cap[0] & mask)) |=> s_q.pin[0])
    else $error("pwm output not raised on match");

  a_pwm_enable_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf_n && pwm_n[0] && s_q.pwm[1:0] != LEN_8 && !apb_wr)
    |=> s_q.cap[0] == ($past(s_q.arl[0]) & $past(mask)) && !s_q.pin[0])
    else $error("n-bit pwm reload wrong");

  a_pwm16_high: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_tick && pwm_16[0] && s_q.mode[0][MB_ECOM] && counter_value == s_q.cap[0]
     && counter_value != MASK_16) |=> s_q.pin[0])
    else $error("16-bit pwm output not raised");

  a_pwm16_low: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_tick && pwm_16[0] && counter_value == MASK_16) |=> !s_q.pin[0])
    else $error("16-bit pwm output not lowered");

  a_ovf_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.pwm[PB_OVF] && s_q.pwm[PB_OVF_IE]) |-> irq)
    else $error("overflow without interrupt");

endmodule // cc_array

// File: verilog/cc_pkg.sv
// constants for the capture/compare module array
package cc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MAX_MODULES = 8;
  // register byte offsets
  localparam logic [7:0] MODE_BASE = 8'h00;
  localparam logic [7:0] LOW_BASE = 8'h20;
  localparam logic [7:0] HIGH_BASE = 8'h40;
  localparam logic [7:0] PWM_CTRL_ADDR = 8'h60;
  localparam logic [7:0] EVENT_ADDR = 8'h64;
  // module_mode_reg field positions
  localparam int MB_PWM16 = 7;
  localparam int MB_ECOM = 6;
  localparam int MB_RISE = 5;
  localparam int MB_FALL = 4;
  localparam int MB_MATCH = 3;
  localparam int MB_TOGGLE = 2;
  localparam int MB_PWM = 1;
  localparam int MB_IE = 0;
  // pwm_shared_ctrl field positions
  localparam int PB_ARSEL = 7;
  localparam int PB_OVF = 6;
  localparam int PB_OVF_IE = 5;
  localparam int PB_LEN_HI = 1;
  localparam int PB_LEN_LO = 0;
  // cycle length encodings
  localparam logic [1:0] LEN_8 = 2'b00;
  localparam logic [1:0] LEN_9 = 2'b01;
  localparam logic [1:0] LEN_10 = 2'b10;
  localparam logic [1:0] LEN_11 = 2'b11;
  localparam logic [15:0] MASK_8 = 16'h00FF;
  localparam logic [15:0] MASK_9 = 16'h01FF;
  localparam logic [15:0] MASK_10 = 16'h03FF;
  localparam logic [15:0] MASK_11 = 16'h07FF;
  localparam logic [15:0] MASK_16 = 16'hFFFF;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PWM_CTRL_RST = 8'h00;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // stages of the channel input synchroniser
  localparam int SYNC_STAGES = 2;
endpackage
